// [esr_pkg.sv]
/*
 * constants for the exception-state registers: cause codes, register
 * selects, field positions and reset values.
 * assumes the pipeline presents one exception event per cycle at most.
 */
// Operation
// - codes 0 interrupt, 1 write-protect, 2 translation load/fetch, 3 translation store.
// - address error load 4, store 5, fetch bus error 6, data bus error 7.
// - system call 8, breakpoint 9; debug breakpoint in debug writes 9 to debug cause.
// - codes 16 and 17 free for implementation, 18 reserved for coprocessor-2.
// - media-extension unusable 22, debug address match 23, machine check 24.
// - normal cache error leaves cause unchanged; in debug writes 30 to debug cause.
// - resume address register is 32 bits, every bit readable and writable.
// - precise fault captures its address, or branch address plus delay flag in slot.
// - imprecise fault captures the resume instruction address.
// - no resume address update while the exception level flag is set.
// - compressed mode read returns resume bits 31..1 with mode flag in bit 0.
// - compressed mode write loads bits 31..1, clears bit 0, bit 0 sets flag.
// - identification register: options 31:24, company 23:16, type 15:8, revision 7:0.
// - unimplemented options or revision field reads as zeros.
// - with boot select zero, vector base is base bits 31..12 plus twelve zeros.
// - boot select one or debug exception uses fixed default vectors.
// - reset clears the writable base field, giving base 16#8000.0000.
// - base bits 31:30 read 2#10, writes ignored; bits 11:10 read zero.
// - adding the offset must not carry from bit 29 into bit 30.
// - cache error forces bit 29 of the final base to one.
// - read-only 10-bit core index in low base bits, from input pins.
// - cause code stored in the read-only field at cause bits 6 down to 2.
package esr_pkg;
    // cause codes
    localparam logic [4:0] EXC_INT      = 5'h00;
    localparam logic [4:0] EXC_MOD      = 5'h01;
    localparam logic [4:0] EXC_TLB_LD   = 5'h02;
    localparam logic [4:0] EXC_TLB_ST   = 5'h03;
    localparam logic [4:0] EXC_ADR_LD   = 5'h04;
    localparam logic [4:0] EXC_ADR_ST   = 5'h05;
    localparam logic [4:0] EXC_BUS_IF   = 5'h06;
    localparam logic [4:0] EXC_BUS_DA   = 5'h07;
    localparam logic [4:0] EXC_SYS      = 5'h08;
    localparam logic [4:0] EXC_BREAK    = 5'h09;
    localparam logic [4:0] EXC_IMPL0    = 5'h10;
    localparam logic [4:0] EXC_IMPL1    = 5'h11;
    localparam logic [4:0] EXC_C2       = 5'h12;
    localparam logic [4:0] EXC_MEDIA    = 5'h16;
    localparam logic [4:0] EXC_WATCH    = 5'h17;
    localparam logic [4:0] EXC_MACHINE_FAULT   = 5'h18;
    localparam logic [4:0] EXC_CACHE    = 5'h1e;
    // register selects on the move port
    localparam logic [1:0] SEL_RESUME   = 2'h0;
    localparam logic [1:0] SEL_IDENT    = 2'h1;
    localparam logic [1:0] SEL_VBASE    = 2'h2;
    localparam logic [1:0] SEL_CAUSE    = 2'h3;
    // field positions
    localparam int CAUSE_CODE_LO = 2;
    localparam int CAUSE_CODE_HI = 6;
    localparam int CAUSE_BD_BIT  = 31;
    localparam int VB_FIELD_LO   = 12;
    localparam int VB_FIELD_HI   = 29;
    localparam int CORE_IDX_W    = 10;
    // reset and fixed values
    localparam logic [17:0] VB_FIELD_RST = 18'h00000;
    localparam logic [1:0]  VB_TOP_BITS  = 2'b10;
    // fixed default bases: normal, boot and debug, arbitrary plain defaults
    localparam logic [31:0] BASE_NORMAL  = 32'h80000000;
    localparam logic [31:0] BASE_BOOT    = 32'hbfc00200;
    localparam logic [31:0] BASE_DEBUG   = 32'hbfc00480;
endpackage : esr_pkg

// [esr_ident.sv]
/*
 * identification register assembly.
 * assumes field values are fixed at build time; identity values arbitrary.
 */
`timescale 1ns/1ps
module esr_ident #(
    parameter bit         HAS_OPTIONS  = 1'b0,
    parameter bit         HAS_REVISION = 1'b1,
    parameter logic [7:0] OPTIONS      = 8'h00,  // value is arbitrary
    parameter logic [7:0] COMPANY      = 8'h5a,  // value is arbitrary
    parameter logic [7:0] PROC_TYPE    = 8'h21,  // value is arbitrary
    parameter logic [7:0] REVISION     = 8'h03   // value is arbitrary
) (
    output wire logic [31:0] o_ident
);
    // absent optional fields read as zero
    wire logic [7:0] opt_w = HAS_OPTIONS  ? OPTIONS  : 8'h00;
    wire logic [7:0] rev_w = HAS_REVISION ? REVISION : 8'h00;
    assign o_ident = {opt_w, COMPANY, PROC_TYPE, rev_w};
endmodule : esr_ident

// [esr_vector.sv]
/*
 * exception vector address formation from base and offset.
 * assumes the offset is under 16#2000_0000 and base field bits obey spacing.
 */
`timescale 1ns/1ps
module esr_vector
    import esr_pkg::*;
(
    input  wire logic [31:0] i_base,
    input  wire logic        i_boot_sel,
    input  wire logic        i_debug,
    input  wire logic        i_cache_err,
    input  wire logic [15:0] i_offset,
    output wire logic [31:0] o_vector
);
    // software base or fixed defaults
    wire logic [31:0] base_w = i_debug    ? BASE_DEBUG :
                               i_boot_sel ? BASE_BOOT  :
                               {i_base[31:12], 12'h000};
    wire logic [31:0] base_c = i_cache_err ? (base_w | 32'h20000000)
                                           : base_w;
    // low 30 bits add alone so no carry reaches bit 30
    wire logic [29:0] low_w  = base_c[29:0] + {14'h0000, i_offset};
    assign o_vector = i_debug ? base_w : {base_c[31:30], low_w};
endmodule : esr_vector

// [esr_top.sv]
/*
 * exception-state registers: cause code, resume address, identification,
 * vector base with core index, vector address output.
 * assumes the pipeline raises i_exc_valid for one cycle per exception and
 * that register moves and exceptions do not collide (exception wins).
 */
`timescale 1ns/1ps
module esr_top
    import esr_pkg::*;
#(
    parameter bit HAS_COMPRESSED = 1'b1
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // exception event from the pipeline
    input  wire logic                  i_exc_valid,
    input  wire logic [4:0]            i_exc_code,
    input  wire logic                  i_exc_precise,
    input  wire logic                  i_exc_in_slot,
    input  wire logic [31:0]           i_exc_pc,
    input  wire logic [31:0]           i_branch_pc,
    input  wire logic [31:0]           i_resume_pc,
    input  wire logic                  i_exc_level,
    input  wire logic                  i_debug_mode,
    input  wire logic                  i_debug_exc,
    input  wire logic                  i_boot_sel,
    input  wire logic [15:0]           i_vec_offset,
    // register moves
    input  wire logic                  i_mv_rd,
    input  wire logic                  i_mv_wr,
    input  wire logic [1:0]            i_mv_sel,
    input  wire logic [31:0]           i_mv_wdata,
    input  wire logic                  i_instr_mode,
    // straps
    input  wire logic [CORE_IDX_W-1:0] i_core_index,
    // outputs
    output logic [31:0]                o_mv_rdata,
    output logic                       o_mv_rvalid,
    output logic [31:0]                o_vector,
    output logic                       o_vector_valid,
    output logic [4:0]                 o_debug_cause,
    output logic                       o_debug_cause_valid,
    output logic                       o_instr_set_flag,
    output logic [31:0]                o_cause
);
    import esr_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [31:0]           resume_q,    resume_d;
    logic                  isa_q,       isa_d;
    logic [4:0]            code_q,      code_d;
    logic                  slot_q,      slot_d;
    logic [17:0]           vbf_q,       vbf_d;
    logic [CORE_IDX_W-1:0] core_q;
    logic                  core_done_q;
    logic [31:0]           rdata_q;
    logic                  rvalid_q;
    logic [31:0]           vec_q;
    logic                  vec_v_q;
    logic [4:0]            dcause_q;
    logic                  dcause_v_q;

    wire logic [31:0] ident_w;
    wire logic [31:0] vector_w;

    esr_ident u_ident (
        .o_ident (ident_w)
    );

    // ---------------------------------------------------------------
    // exception classification
    // ---------------------------------------------------------------
    wire logic cache_err_w  = i_exc_code == EXC_CACHE;
    wire logic debug_take_w = i_exc_valid & i_debug_mode &
                              ((i_exc_code == EXC_BREAK) | cache_err_w);
    // normal-mode exceptions; cache errors leave cause alone
    wire logic norm_exc_w   = i_exc_valid & ~i_debug_mode;
    wire logic cause_upd_w  = norm_exc_w & ~cache_err_w;
    wire logic resume_upd_w = norm_exc_w & ~i_exc_level;

    // all codes pass through unchanged; the encoding lives in the package
    wire logic [4:0]  next_code_w = i_exc_code;
    wire logic [31:0] capture_w   = ~i_exc_precise ? i_resume_pc :
                                    i_exc_in_slot  ? i_branch_pc :
                                                     i_exc_pc;

    // ---------------------------------------------------------------
    // register moves
    // ---------------------------------------------------------------
    wire logic wr_resume_w = i_mv_wr & (i_mv_sel == SEL_RESUME) & ~resume_upd_w;
    wire logic wr_vbase_w  = i_mv_wr & (i_mv_sel == SEL_VBASE);

    // without the compressed set, bit 0 is stored as written
    wire logic [31:0] wr_resume_val_w = HAS_COMPRESSED ?
                                        {i_mv_wdata[31:1], 1'b0}
                                        : i_mv_wdata;
    wire logic [31:0] rd_resume_w = HAS_COMPRESSED ?
                                    {resume_q[31:1], isa_q}
                                    : resume_q;
    wire logic [31:0] vbase_w  = {VB_TOP_BITS, vbf_q, 2'b00,
                                  core_q};
    wire logic [31:0] cause_w  = {slot_q, 24'h000000, code_q, 2'b00};

    wire logic [31:0] rd_mux_w = (i_mv_sel == SEL_RESUME) ? rd_resume_w :
                                 (i_mv_sel == SEL_IDENT)  ? ident_w     :
                                 (i_mv_sel == SEL_VBASE)  ? vbase_w     :
                                                            cause_w;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        resume_d = resume_q;
        isa_d    = isa_q;
        code_d   = code_q;
        slot_d   = slot_q;
        vbf_d    = vbf_q;
        if (resume_upd_w) begin
            resume_d = capture_w;
            isa_d    = i_instr_mode;
        end else if (wr_resume_w) begin
            resume_d = wr_resume_val_w;
            isa_d    = HAS_COMPRESSED ? i_mv_wdata[0] : isa_q;
        end
        if (cause_upd_w) begin
            code_d = next_code_w;
            if (~i_exc_level) begin
                slot_d = i_exc_precise & i_exc_in_slot;
            end
        end
        if (wr_vbase_w) begin
            vbf_d = i_mv_wdata[VB_FIELD_HI:VB_FIELD_LO];
        end
    end

    esr_vector u_vector (
        .i_base      (vbase_w),
        .i_boot_sel  (i_boot_sel),
        .i_debug     (i_debug_exc),
        .i_cache_err (cache_err_w),
        .i_offset    (i_vec_offset),
        .o_vector    (vector_w)
    );

    // ---------------------------------------------------------------
    // flops
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            resume_q <= 32'h00000000;
            isa_q    <= 1'b0;
            code_q   <= 5'h00;
            slot_q   <= 1'b0;
            vbf_q    <= VB_FIELD_RST;
        end else begin
            resume_q <= resume_d;
            isa_q    <= isa_d;
            code_q   <= code_d;
            slot_q   <= slot_d;
            vbf_q    <= vbf_d;
        end
    end

    // core index caught once after each reset release so reads hold until the next reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            core_q      <= '0;
            core_done_q <= 1'b0;
        end else if (!core_done_q) begin
            core_q      <= i_core_index;
            core_done_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q    <= 32'h00000000;
            rvalid_q   <= 1'b0;
            vec_q      <= 32'h00000000;
            vec_v_q    <= 1'b0;
            dcause_q   <= 5'h00;
            dcause_v_q <= 1'b0;
        end else begin
            rdata_q    <= i_mv_rd ? rd_mux_w : rdata_q;
            rvalid_q   <= i_mv_rd;
            vec_q      <= i_exc_valid ? vector_w : vec_q;
            vec_v_q    <= i_exc_valid;
            dcause_q   <= debug_take_w ? i_exc_code : dcause_q;
            dcause_v_q <= debug_take_w;
        end
    end

    assign o_mv_rdata          = rdata_q;
    assign o_mv_rvalid         = rvalid_q;
    assign o_vector            = vec_q;
    assign o_vector_valid      = vec_v_q;
    assign o_debug_cause       = dcause_q;
    assign o_debug_cause_valid = dcause_v_q;
    assign o_instr_set_flag    = isa_q;
    assign o_cause             = cause_w;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    resume_hold_a: assert property ((i_exc_valid & i_exc_level & ~i_mv_wr)
        |=> $stable(resume_q)) else $error("resume changed at exception level");
    resume_cap_a: assert property ((i_exc_valid & ~i_debug_mode & ~i_exc_level
        & i_exc_precise & ~i_exc_in_slot) |=> resume_q == $past(i_exc_pc))
        else $error("precise address not captured");
    slot_cap_a: assert property ((i_exc_valid & ~i_debug_mode & ~i_exc_level
        & i_exc_precise & i_exc_in_slot & ~cache_err_w)
        |=> resume_q == $past(i_branch_pc) && slot_q)
        else $error("delay slot capture wrong");
    async_cap_a: assert property ((i_exc_valid & ~i_debug_mode & ~i_exc_level
        & ~i_exc_precise) |=> resume_q == $past(i_resume_pc))
        else $error("resume pc not captured");
    cache_keep_a: assert property ((i_exc_valid & cache_err_w)
        |=> $stable(code_q)) else $error("cache error changed cause");
    mode_write_a: assert property ((i_mv_wr & (i_mv_sel == SEL_RESUME) & ~i_exc_valid)
        |=> resume_q[0] == 1'b0 && isa_q == $past(i_mv_wdata[0]))
        else $error("compressed write split wrong");
    top_bits_a: assert property (vbase_w[31:30] == VB_TOP_BITS && vbase_w[11:10] == 2'b00)
        else $error("fixed base bits wrong");
    core_stable_a: assert property (core_done_q |=> $stable(core_q))
        else $error("core index moved");
    vec_base_a: assert property ((i_exc_valid & ~i_boot_sel & ~i_debug_exc & ~cache_err_w)
        |=> vec_q[31:30] == VB_TOP_BITS)
        else $error("vector left unmapped segment");
    dbg_code_a: assert property (debug_take_w |=> dcause_v_q && dcause_q == $past(i_exc_code))
        else $error("debug cause not written");
    rd_mode_a: assert property ((HAS_COMPRESSED & i_mv_rd & (i_mv_sel == SEL_RESUME))
        |=> o_mv_rdata[0] == $past(isa_q))
        else $error("mode flag not in read bit 0");
    cache_seg_a: assert property ((i_exc_valid & cache_err_w & ~i_debug_exc)
        |=> vec_q[29] == 1'b1)
        else $error("cache vector not uncached");
    debug_vec_a: assert property ((i_exc_valid & i_debug_exc)
        |=> vec_q == BASE_DEBUG)
        else $error("debug vector not fixed");

    cov_slot_c:   cover property (i_exc_valid & i_exc_in_slot & ~i_exc_level);
    cov_nested_c: cover property (i_exc_valid & i_exc_level);
    cov_cache_c:  cover property (i_exc_valid & cache_err_w);
    cov_write_c:  cover property (i_mv_wr ##1 i_mv_rd);
endmodule : esr_top

// [esr_pipe_model.sv]
/*
 * pipeline-side model: launches one exception event per call to fire.
 * assumes the bench calls fire from procedural code, one event at a time.
 */
`timescale 1ns/1ps
module esr_pipe_model (
    input  wire logic   i_clk,
    output logic        o_exc_valid,
    output logic [4:0]  o_exc_code,
    output logic        o_exc_precise,
    output logic        o_exc_in_slot,
    output logic [31:0] o_exc_pc,
    output logic [31:0] o_branch_pc,
    output logic [31:0] o_resume_pc,
    output logic        o_exc_level,
    output logic        o_debug_mode,
    output logic        o_debug_exc,
    output logic [15:0] o_vec_offset
);
    initial begin
        {o_exc_valid, o_exc_code, o_exc_precise, o_exc_in_slot} = '0;
        {o_exc_pc, o_branch_pc, o_resume_pc} = '0;
        {o_exc_level, o_debug_mode, o_debug_exc, o_vec_offset} = '0;
    end
    // ------------------------------------------------------------------
    // event launch: fl = {debug exc, debug mode, level, in slot, imprecise}
    // ------------------------------------------------------------------
    task automatic fire(input logic [4:0] code, input logic [31:0] pc,
                        input logic [4:0] fl, input logic [15:0] off);
        @(negedge i_clk);
        o_exc_valid   = 1'b1;
        o_exc_code    = code;
        o_exc_precise = ~fl[0];
        o_exc_in_slot = fl[1];
        o_exc_level   = fl[2];
        o_debug_mode  = fl[3];
        o_debug_exc   = fl[4];
        o_vec_offset  = off;
        o_exc_pc      = pc;
        o_branch_pc   = pc ^ 32'h00000100;
        o_resume_pc   = pc ^ 32'h00000200;
        @(negedge i_clk);
        o_exc_valid   = 1'b0;
        // stale addresses are not held: invert so a late sample shows up
        o_exc_pc      = ~o_exc_pc;
        o_branch_pc   = ~o_branch_pc;
        o_resume_pc   = ~o_resume_pc;
        {o_exc_in_slot, o_exc_level, o_debug_mode, o_debug_exc} = '0;
    endtask : fire
endmodule : esr_pipe_model

// [testbench.sv]
/*
 * self-checking bench for esr_top with the pipeline model on the event side.
 * assumes default parameters of esr_top and esr_ident.
 */
`timescale 1ns/1ps
module testbench;
    import esr_pkg::*;
    typedef struct packed {logic [4:0] code; logic [31:0] pc; logic [15:0] off;} esr_row_s;
    logic i_clk, i_rst, i_boot_sel, i_mv_rd, i_mv_wr, i_instr_mode;
    logic [1:0]  i_mv_sel;
    logic [31:0] i_mv_wdata, o_mv_rdata, o_vector, o_cause, e_pc, b_pc, r_pc;
    logic [9:0]  i_core_index;
    logic [4:0]  o_debug_cause, e_code;
    logic [15:0] e_off;
    logic o_mv_rvalid, o_vector_valid, o_debug_cause_valid, o_instr_set_flag;
    logic e_valid, e_prec, e_slot, e_lvl, e_dbgm, e_dbgx;
    int   err_count = 0;
    int   tests_run = 0;
    logic [31:0] vals [4] = '{32'h00001235, 32'hfffffffe, 32'hffffffff, 32'h0};
    esr_row_s rows [16] = '{
        '{5'h00, 32'h00401000, 16'h0180}, '{5'h01, 32'h00401004, 16'h0000},
        '{5'h02, 32'h00401008, 16'h0180}, '{5'h03, 32'h0040100c, 16'h0200},
        '{5'h04, 32'h00401010, 16'h0180}, '{5'h05, 32'h00401014, 16'h0380},
        '{5'h06, 32'h00401018, 16'h0180}, '{5'h07, 32'hfffffffc, 16'h0180},
        '{5'h08, 32'h00401020, 16'h0180}, '{5'h09, 32'h00401024, 16'h0180},
        '{5'h10, 32'h00401028, 16'h0180}, '{5'h11, 32'h0040102c, 16'h0180},
        '{5'h12, 32'h00401030, 16'h0180}, '{5'h16, 32'h00401034, 16'h0180},
        '{5'h17, 32'h00401038, 16'h0180}, '{5'h18, 32'h0040103c, 16'hfffc}};
    esr_pipe_model pipe_i (.i_clk(i_clk), .o_exc_valid(e_valid), .o_exc_code(e_code),
        .o_exc_precise(e_prec), .o_exc_in_slot(e_slot), .o_exc_pc(e_pc), .o_branch_pc(b_pc),
        .o_resume_pc(r_pc), .o_exc_level(e_lvl), .o_debug_mode(e_dbgm),
        .o_debug_exc(e_dbgx), .o_vec_offset(e_off));
    esr_top esr_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_exc_valid(e_valid),
        .i_exc_code(e_code), .i_exc_precise(e_prec), .i_exc_in_slot(e_slot),
        .i_exc_pc(e_pc), .i_branch_pc(b_pc), .i_resume_pc(r_pc), .i_exc_level(e_lvl),
        .i_debug_mode(e_dbgm), .i_debug_exc(e_dbgx), .i_boot_sel(i_boot_sel),
        .i_vec_offset(e_off), .i_mv_rd(i_mv_rd), .i_mv_wr(i_mv_wr), .i_mv_sel(i_mv_sel),
        .i_mv_wdata(i_mv_wdata), .i_instr_mode(i_instr_mode), .i_core_index(i_core_index),
        .o_mv_rdata(o_mv_rdata), .o_mv_rvalid(o_mv_rvalid), .o_vector(o_vector),
        .o_vector_valid(o_vector_valid), .o_debug_cause(o_debug_cause),
        .o_debug_cause_valid(o_debug_cause_valid), .o_instr_set_flag(o_instr_set_flag),
        .o_cause(o_cause));
    // ------------------------------------------------------------------
    // clock, shared tasks
    // ------------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic finish_test();
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : check
    task automatic do_reset();
        @(negedge i_clk);
        i_rst = 1'b1;
        repeat (4) @(negedge i_clk);
        i_rst = 1'b0;
    endtask : do_reset
    task automatic mv_write(input logic [1:0] sel, input logic [31:0] data);
        @(negedge i_clk);
        {i_mv_wr, i_mv_sel, i_mv_wdata} = {1'b1, sel, data};
        @(negedge i_clk);
        i_mv_wr = 1'b0;
    endtask : mv_write
    task automatic mv_read(input logic [1:0] sel, input logic [31:0] exp);
        @(negedge i_clk);
        {i_mv_rd, i_mv_sel} = {1'b1, sel};
        @(negedge i_clk);
        i_mv_rd = 1'b0;
        check({31'h0, o_mv_rvalid}, 32'h1);
        check(o_mv_rdata, exp);
    endtask : mv_read
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {i_boot_sel, i_mv_rd, i_mv_wr, i_instr_mode, i_mv_sel} = '0;
        i_rst        = 1'b1;
        i_mv_wdata   = 32'h0;
        i_core_index = 10'h2a5;
        do_reset();
        mv_read(SEL_VBASE, 32'h800002a5);
        i_core_index = 10'h155;
        mv_read(SEL_VBASE, 32'h800002a5);
        mv_read(SEL_IDENT, 32'h005a2103);
        mv_write(SEL_IDENT, 32'hffffffff);
        mv_read(SEL_IDENT, 32'h005a2103);
        for (int k = 0; k < 16; k++) begin
            pipe_i.fire(rows[k].code, rows[k].pc, 5'h00, rows[k].off);
            check({31'h0, o_vector_valid}, 32'h1);
            check(o_vector, 32'h80000000 + rows[k].off);
            check(o_cause, {25'h0, rows[k].code, 2'h0});
            check({27'h0, o_cause[6:2]}, {27'h0, rows[k].code});
            mv_read(SEL_RESUME, rows[k].pc);
        end
        for (int k = 0; k < 4; k++) begin
            mv_write(SEL_RESUME, vals[k]);
            mv_read(SEL_RESUME, vals[k]);
            check({31'h0, o_instr_set_flag}, {31'h0, vals[k][0]});
        end
        pipe_i.fire(EXC_ADR_LD, 32'h00402000, 5'b00010, 16'h0180);
        mv_read(SEL_RESUME, 32'h00402100);
        check(o_cause, 32'h80000010);
        pipe_i.fire(EXC_INT, 32'h00402000, 5'b00001, 16'h0180);
        mv_read(SEL_RESUME, 32'h00402200);
        pipe_i.fire(EXC_ADR_ST, 32'h00402040, 5'b00110, 16'h0180);
        mv_read(SEL_RESUME, 32'h00402200);
        check(o_cause, 32'h00000014);
        pipe_i.fire(EXC_CACHE, 32'h00402000, 5'b00000, 16'h0100);
        check(o_vector, 32'ha0000100);
        check(o_cause, 32'h00000014);
        pipe_i.fire(EXC_BREAK, 32'h00402000, 5'b01000, 16'h0000);
        check({o_debug_cause_valid, o_debug_cause}, {1'b1, EXC_BREAK});
        check(o_cause, 32'h00000014);
        pipe_i.fire(EXC_CACHE, 32'h00402000, 5'b01000, 16'h0000);
        check({o_debug_cause_valid, o_debug_cause}, {1'b1, EXC_CACHE});
        pipe_i.fire(EXC_MOD, 32'h00402000, 5'b10000, 16'h0180);
        check(o_vector, BASE_DEBUG);
        i_boot_sel = 1'b1;
        pipe_i.fire(EXC_INT, 32'h00402000, 5'b00000, 16'h0180);
        check(o_vector, BASE_BOOT + 32'h180);
        mv_write(SEL_VBASE, 32'hffffffff);
        mv_read(SEL_VBASE, 32'hbffff2a5);
        @(negedge i_clk);
        i_boot_sel = 1'b0;
        pipe_i.fire(EXC_INT, 32'h00402000, 5'b00000, 16'h1180);
        check(o_vector, 32'h80000180);
        do_reset();
        mv_read(SEL_VBASE, 32'h80000155);
        mv_read(SEL_CAUSE, 32'h0);
        finish_test();
    end
    initial begin
        #50000;
        err_count++;
        finish_test();
    end
endmodule : testbench
